// ==== lcsd_row_scan.sv ====
// Common row scan driver: 64-stage bidirectional scan register, row level selection and master timing generator.
// Assumes every pin input is asynchronous to clk; two-way pins come as input, output and active-low enable.
module lcsd_row_scan
  import lcsd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Straps and oscillator.
  input wire logic master_slave_select,
  input wire logic shift_edge_select,
  input wire logic shift_direction_select,
  input wire logic duty_select_low,
  input wire logic duty_select_high,
  input wire logic frequency_select,
  input wire logic standby_pin,
  input wire logic osc_clock_input,
  // Shift clock line.
  input wire logic shift_clock_line_in,
  output logic shift_clock_line_out,
  output logic shift_clock_line_oe_n,
  // Phase line.
  input wire logic ac_phase_in,
  output logic ac_phase_out,
  output logic ac_phase_oe_n,
  // Left and right scan data terminals.
  input wire logic left_scan_data_in,
  output logic left_scan_data_out,
  output logic left_scan_data_oe_n,
  input wire logic right_scan_data_in,
  output logic right_scan_data_out,
  output logic right_scan_data_oe_n,
  // Row outputs and segment driver timing.
  output logic [2*lcsd_pkg::STAGES-1:0] row_levels,
  output logic frame_pulse_out,
  output logic op_clock_a,
  output logic op_clock_b,
  output logic scan_overrun
);
  import lcsd_pkg::*;

  typedef struct packed {
    logic [ST_BITS-1:0] st_s1;
    logic [ST_BITS-1:0] st_s2;
    logic [DY_BITS-1:0] dy_s1;
    logic [DY_BITS-1:0] dy_s2;
    logic osc_prev;
    logic line_prev;
    logic [5:0] osc_cnt;
    logic [7:0] row_cnt;
    logic clk_line_r;
    logic phase_r;
    logic start_bit_r;
    logic frame_r;
    logic phi_div_r;
    logic phi1_r;
    logic phi2_r;
    logic [STAGES-1:0] shreg_r;
    logic [2*STAGES-1:0] lvl_r;
    logic left_out_r;
    logic right_out_r;
    logic left_oe_n_r;
    logic right_oe_n_r;
    logic line_oe_n_r;
    logic phase_oe_n_r;
    logic overrun_r;
  } lcsd_state_t;

  // Maps a stage bit and the phase to a drive level code.
  function automatic logic [1:0] level_of(input logic bit_v, input logic phase_v);
    if (phase_v) begin
      level_of = bit_v ? LVL_SELECTED_B : LVL_UNSELECTED_B;
    end else begin
      level_of = bit_v ? LVL_SELECTED_A : LVL_UNSELECTED_A;
    end
  endfunction : level_of

  // Rows per frame from the two duty select straps.
  function automatic logic [7:0] duty_rows(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0: duty_rows = DUTY_48;
      2'h1: duty_rows = DUTY_64;
      2'h2: duty_rows = DUTY_96;
      default: duty_rows = DUTY_128;
    endcase
  endfunction : duty_rows

  lcsd_state_t s;
  lcsd_state_t n;
  lcsd_stream_if #(.WIDTH(1)) st ();

  logic ms;
  logic dir;
  logic edge_sel;
  logic standby_ok;
  logic [7:0] duty;
  logic [5:0] row_len;
  logic osc_tick;
  logic line_lvl;
  logic phase_src;
  logic shift_ev;
  logic in_bit;
  logic gen_step;
  logic row_end;
  logic frame_end;

  // The buffer decouples shift events from the register; when it is full the master generator waits.
  lcsd_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .port(st.fifo_side)
  );

  // Decoded straps and edges; everything reads the second synchroniser stage only.
  assign ms = s.st_s2[ST_MASTER];
  assign dir = s.st_s2[ST_DIR];
  assign edge_sel = s.st_s2[ST_EDGE];
  assign standby_ok = s.st_s2[ST_STANDBY];
  assign duty = duty_rows(s.st_s2[ST_DUTY_HI], s.st_s2[ST_DUTY_LO]);
  assign row_len = s.st_s2[ST_FREQ] ? ROW_TICKS_FAST : ROW_TICKS_SLOW;
  assign osc_tick = s.dy_s2[DY_OSC] && !s.osc_prev;
  assign line_lvl = ms ? s.clk_line_r : s.dy_s2[DY_LINE];
  assign phase_src = ms ? s.phase_r : s.dy_s2[DY_PHASE];
  assign shift_ev = edge_sel ? (line_lvl && !s.line_prev) : (!line_lvl && s.line_prev);
  assign in_bit = ms ? s.start_bit_r : (dir ? s.dy_s2[DY_LEFT] : s.dy_s2[DY_RIGHT]);
  assign gen_step = ms && osc_tick && st.push_ready;
  assign row_end = (s.osc_cnt >= row_len - 6'h01);
  assign frame_end = (s.row_cnt >= duty - 8'h01);

  // Buffer hookup: every detected shift edge offers one bit; the register drains only out of standby.
  assign st.push_valid = shift_ev;
  assign st.push_data = in_bit;
  assign st.pop_ready = standby_ok;

  // Next state of the whole block.
  always_comb begin
    n = s;
    n.st_s1 = {standby_pin, frequency_select, duty_select_high, duty_select_low,
               shift_direction_select, shift_edge_select, master_slave_select};
    n.st_s2 = s.st_s1;
    n.dy_s1 = {right_scan_data_in, left_scan_data_in, ac_phase_in, shift_clock_line_in, osc_clock_input};
    n.dy_s2 = s.dy_s1;
    n.osc_prev = s.dy_s2[DY_OSC];
    n.line_prev = line_lvl;
    // Timing generator; a full buffer freezes it so no scan bit is ever dropped in master mode.
    if (!ms) begin
      n.osc_cnt = '0;
      n.row_cnt = '0;
      n.clk_line_r = 1'b0;
      n.start_bit_r = 1'b0;
      n.frame_r = 1'b0;
      n.phi_div_r = 1'b0;
    end else if (gen_step) begin
      n.phi_div_r = !s.phi_div_r;
      if (row_end) begin
        n.osc_cnt = '0;
        n.row_cnt = frame_end ? 8'h00 : s.row_cnt + 8'h01;
        n.start_bit_r = frame_end;
        n.frame_r = frame_end;
        if (frame_end) begin
          n.phase_r = !s.phase_r;
        end
      end else begin
        n.osc_cnt = s.osc_cnt + 6'h01;
      end
      n.clk_line_r = (n.osc_cnt >= (row_len >> 1));
    end
    // Operating clocks are the halved oscillator in both phases; they rest low in slave mode.
    n.phi1_r = ms && s.phi_div_r;
    n.phi2_r = ms && !s.phi_div_r;
    // A shift edge that finds the buffer full is lost; the sticky flag reports it until reset.
    if (shift_ev && !st.push_ready) begin
      n.overrun_r = 1'b1;
    end
    // Scan register: direction high enters at row 1 and walks toward row 64.
    if (st.pop_valid && st.pop_ready) begin
      if (dir) begin
        n.shreg_r = {s.shreg_r[STAGES-2:0], st.pop_data};
      end else begin
        n.shreg_r = {st.pop_data, s.shreg_r[STAGES-1:1]};
      end
    end
    // Row levels; stage k drives row k+1.
    for (int k = 0; k < STAGES; k++) begin
      n.lvl_r[2*k +: 2] = level_of(s.shreg_r[k], phase_src);
    end
    // Terminal roles; the entry end echoes the start bit in master mode.
    n.left_out_r = dir ? s.start_bit_r : s.shreg_r[0];
    n.right_out_r = dir ? s.shreg_r[STAGES-1] : s.start_bit_r;
    n.left_oe_n_r = !ms && dir;
    n.right_oe_n_r = !ms && !dir;
    n.line_oe_n_r = !ms;
    n.phase_oe_n_r = !ms;
  end

  // State register; the straps sit in synchronisers, so a mode change lands two cycles later.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.lvl_r <= {STAGES{LVL_UNSELECTED_A}};
      s.left_oe_n_r <= 1'b1;
      s.right_oe_n_r <= 1'b1;
      s.line_oe_n_r <= 1'b1;
      s.phase_oe_n_r <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register.
  assign shift_clock_line_out = s.clk_line_r;
  assign shift_clock_line_oe_n = s.line_oe_n_r;
  assign ac_phase_out = s.phase_r;
  assign ac_phase_oe_n = s.phase_oe_n_r;
  assign left_scan_data_out = s.left_out_r;
  assign left_scan_data_oe_n = s.left_oe_n_r;
  assign right_scan_data_out = s.right_out_r;
  assign right_scan_data_oe_n = s.right_oe_n_r;
  assign row_levels = s.lvl_r;
  assign frame_pulse_out = s.frame_r;
  assign op_clock_a = s.phi1_r;
  assign op_clock_b = s.phi2_r;
  assign scan_overrun = s.overrun_r;

  // Checks next to the logic they guard.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Each pop moves every stage by one place and takes the popped bit in at the entry end.
  a_shift_right_moves: assert property ((st.pop_valid && st.pop_ready && dir) |=>
    (s.shreg_r[STAGES-1:1] == $past(s.shreg_r[STAGES-2:0]) && s.shreg_r[0] == $past(st.pop_data)))
    else $error("Scan register did not shift toward the right end.");
  a_shift_left_moves: assert property ((st.pop_valid && st.pop_ready && !dir) |=>
    (s.shreg_r[STAGES-2:0] == $past(s.shreg_r[STAGES-1:1]) && s.shreg_r[STAGES-1] == $past(st.pop_data)))
    else $error("Scan register did not shift toward the left end.");
  // Without a popped bit the register must hold, whatever the generator does.
  a_hold_no_pop: assert property (!(st.pop_valid && st.pop_ready) |=> $stable(s.shreg_r))
    else $error("Scan register moved without a shift edge.");
  // Both end rows follow their stage bit and the phase one cycle later.
  a_row_level_map: assert property (1'b1 |=>
    (row_levels[1:0] == level_of($past(s.shreg_r[0]), $past(phase_src)) &&
     row_levels[2*STAGES-1 -: 2] == level_of($past(s.shreg_r[STAGES-1]), $past(phase_src))))
    else $error("Row level does not match stage bit and phase.");
  // The mode decides who drives the shared lines.
  a_master_drives: assert property (ms |=> (!shift_clock_line_oe_n && !ac_phase_oe_n &&
    !left_scan_data_oe_n && !right_scan_data_oe_n))
    else $error("Master mode left a shared line undriven.");
  a_slave_stops: assert property (!ms ##1 !ms |-> (s.osc_cnt == 6'h00 && !shift_clock_line_out &&
    shift_clock_line_oe_n && ac_phase_oe_n))
    else $error("Timing generator ran in slave mode.");
  a_slave_right_out: assert property ((!ms && dir) |=> (left_scan_data_oe_n && !right_scan_data_oe_n &&
    right_scan_data_out == $past(s.shreg_r[STAGES-1])))
    else $error("Slave terminal roles wrong for direction high.");
  // A slave shift edge must match the selected polarity of the synchronised line, seen one cycle apart.
  a_edge_polarity: assert property ((!ms && !$past(ms) && st.push_valid) |->
    (s.dy_s2[DY_LINE] == edge_sel && $past(s.dy_s2[DY_LINE]) != edge_sel))
    else $error("Shift edge does not match the selected polarity.");
  // Frame start and buffer stall of the master generator.
  a_frame_toggle: assert property ((gen_step && row_end && frame_end) |=>
    (s.phase_r != $past(s.phase_r) && frame_pulse_out && s.start_bit_r && s.row_cnt == 8'h00))
    else $error("Frame start did not toggle phase and pulse frame.");
  a_stall_full: assert property ((ms && !st.push_ready) |=> $stable(s.osc_cnt))
    else $error("Generator advanced while the buffer was full.");
  // Operating clocks stay complementary in master mode, so a segment driver never sees both high.
  a_op_clock_pair: assert property (ms |=> (op_clock_a != op_clock_b))
    else $error("Operating clocks are not complementary in master mode.");
  // The entry terminal carries the start bit out while this device makes the timing.
  a_master_start_out: assert property ((ms && dir) |=> (left_scan_data_out == $past(s.start_bit_r)))
    else $error("Left terminal does not carry the start bit in master mode.");
  // Only the local generator makes frame pulses.
  a_slave_no_frame: assert property (!ms |=> !frame_pulse_out)
    else $error("Frame pulse seen in slave mode.");
  // A lost scan bit must stay visible until the next reset, or a user could miss it.
  a_overrun_sticky: assert property (scan_overrun |=> scan_overrun)
    else $error("Overrun flag cleared without a reset.");

  // Covers for the main scenarios.
  c_master_frame: cover property (gen_step && row_end && frame_end);
  c_slow_row: cover property (gen_step && row_end && row_len == ROW_TICKS_SLOW);
  c_slave_shift_left: cover property (!ms && !dir && st.pop_valid && st.pop_ready);
  c_buffer_full: cover property (ms && !st.push_ready);
  c_falling_edge_shift: cover property (!edge_sel && shift_ev);

endmodule : lcsd_row_scan

// ==== lcsd_pkg.sv ====
// Package of the common row scan driver: sizes, drive level codes, strap bit positions and scan timing counts.
// Assumes the including modules import it whole; nothing here depends on the surroundings.
package lcsd_pkg;

  // Number of register stages and row outputs.
  localparam int STAGES = 64;

  // Row drive level codes, two bits per row output.
  localparam logic [1:0] LVL_SELECTED_A = 2'h0;
  localparam logic [1:0] LVL_SELECTED_B = 2'h1;
  localparam logic [1:0] LVL_UNSELECTED_A = 2'h2;
  localparam logic [1:0] LVL_UNSELECTED_B = 2'h3;

  // Bit positions of the synchronised strap inputs.
  localparam int ST_MASTER = 0;
  localparam int ST_EDGE = 1;
  localparam int ST_DIR = 2;
  localparam int ST_DUTY_LO = 3;
  localparam int ST_DUTY_HI = 4;
  localparam int ST_FREQ = 5;
  localparam int ST_STANDBY = 6;
  localparam int ST_BITS = 7;

  // Bit positions of the synchronised link inputs.
  localparam int DY_OSC = 0;
  localparam int DY_LINE = 1;
  localparam int DY_PHASE = 2;
  localparam int DY_LEFT = 3;
  localparam int DY_RIGHT = 4;
  localparam int DY_BITS = 5;

  // Rows per frame for each duty ratio.
  localparam logic [7:0] DUTY_48 = 8'h30;
  localparam logic [7:0] DUTY_64 = 8'h40;
  localparam logic [7:0] DUTY_96 = 8'h60;
  localparam logic [7:0] DUTY_128 = 8'h80;

  // Oscillator ticks per row with the frequency select high; low doubles it.
  localparam logic [5:0] ROW_TICKS_FAST = 6'h10;
  localparam logic [5:0] ROW_TICKS_SLOW = 6'h20;

  // Depth of the scan bit buffer.
  localparam int FIFO_DEPTH = 4;

endpackage : lcsd_pkg

// ==== lcsd_stream_if.sv ====
// Interface carrying scan bits from the edge detector into the buffer and from the buffer to the shift register.
// Assumes both ends run on the same clock; it holds wires only.
interface lcsd_stream_if #(
  parameter int WIDTH = 1
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  // The buffer end.
  modport fifo_side (
    input push_valid,
    input push_data,
    input pop_ready,
    output push_ready,
    output pop_valid,
    output pop_data
  );

  // The end that fills and drains the buffer.
  modport user_side (
    output push_valid,
    output push_data,
    output pop_ready,
    input push_ready,
    input pop_valid,
    input pop_data
  );
endinterface : lcsd_stream_if

// ==== lcsd_fifo.sv ====
// Small first-in first-out buffer for scan bits, with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; the port's width matches WIDTH.
module lcsd_fifo
  import lcsd_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = lcsd_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Stream port.
  lcsd_stream_if.fifo_side port
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } lcsd_fifo_state_t;

  lcsd_fifo_state_t s_r;
  lcsd_fifo_state_t s_nxt;
  logic do_push;
  logic do_pop;

  // Flags come from the count alone, so full and empty never lie about the stored words.
  assign port.push_ready = (s_r.cnt != FULL);
  assign port.pop_valid = (s_r.cnt != '0);
  assign port.pop_data = s_r.mem[s_r.rd];
  assign do_push = port.push_valid && port.push_ready;
  assign do_pop = port.pop_valid && port.pop_ready;

  // Next state: write, read and count, pointers wrap at the last slot for any depth.
  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wr] = port.push_data;
      s_nxt.wr = (s_r.wr == LAST) ? '0 : s_r.wr + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rd = (s_r.rd == LAST) ? '0 : s_r.rd + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : lcsd_fifo

// ==== lcsd_ctrl_model.sv ====
// Behavioural display controller that feeds scan timing to the row driver in slave mode.
// Assumes the bench resolves every two-way pin from the row driver's active-low enables.
module lcsd_ctrl_model (
  // Mode and direction seen by the controller.
  input wire logic active,
  input wire logic dir,
  // Lines offered to the driver.
  output logic line_o,
  output logic phase_o,
  output logic left_o,
  output logic right_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line_r = 1'b0;
  logic data_r = 1'b0;
  logic phase_r = 1'b0;
  // A released line shows the inverse of its last value, so stale data never passes for valid.
  assign line_o = active ? line_r : ~line_r;
  assign phase_o = active ? phase_r : ~phase_r;
  assign left_o = (active && dir) ? data_r : ~data_r;
  assign right_o = (active && !dir) ? data_r : ~data_r;
  // One pulse per bit; data holds across both edges, and the line rests low between bits.
  task automatic send_bit(input logic b, input logic ph);
    phase_r = ph;
    data_r = b;
    #62.5 line_r = 1'b1;
    #62.5 line_r = 1'b0;
    #62.5 data_r = ~b;
  endtask : send_bit
endmodule : lcsd_ctrl_model

// ==== testbench.sv ====
// Self-checking bench for the row scan driver: reset, slave scans both ways, buffer overrun, master timing.
// Assumes the controller model in lcsd_ctrl_model.sv; two-way pins are resolved here.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lcsd_pkg::*;
  localparam logic [7:0] DUTY_TAB [4] = '{DUTY_48, DUTY_64, DUTY_96, DUTY_128};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0;
  logic ms, edge_sel, dir, dlo, dhi, freq, stby;
  logic lo, loe, po, poe, lfo, lfoe, rto, rtoe, frame_o, opa, opb, ovr;
  logic [2*STAGES-1:0] rows;
  logic m_line, m_ph, m_l, m_r, lo_q, opa_q;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_line = 0;
  int n_op = 0;
  // Each pin carries whichever party enables it.
  wire w_line = loe ? m_line : lo;
  wire w_ph = poe ? m_ph : po;
  wire w_l = lfoe ? m_l : lfo;
  wire w_r = rtoe ? m_r : rto;

  initial forever #5 clk = ~clk;
  // Oscillator at 40 ns keeps every frame short enough for all four duty ratios.
  initial forever #20 osc = ~osc;

  lcsd_row_scan u_dut (
    .clk(clk), .rst_n(rst_n), .master_slave_select(ms), .shift_edge_select(edge_sel),
    .shift_direction_select(dir), .duty_select_low(dlo), .duty_select_high(dhi),
    .frequency_select(freq), .standby_pin(stby), .osc_clock_input(osc),
    .shift_clock_line_in(w_line), .shift_clock_line_out(lo), .shift_clock_line_oe_n(loe),
    .ac_phase_in(w_ph), .ac_phase_out(po), .ac_phase_oe_n(poe),
    .left_scan_data_in(w_l), .left_scan_data_out(lfo), .left_scan_data_oe_n(lfoe),
    .right_scan_data_in(w_r), .right_scan_data_out(rto), .right_scan_data_oe_n(rtoe),
    .row_levels(rows), .frame_pulse_out(frame_o), .op_clock_a(opa), .op_clock_b(opb), .scan_overrun(ovr)
  );

  lcsd_ctrl_model u_ctrl (
    .active(!ms), .dir(dir), .line_o(m_line), .phase_o(m_ph), .left_o(m_l), .right_o(m_r)
  );

  // Edge counters for master timing, plus the run limit against hangs.
  always @(posedge clk) begin
    lo_q <= lo;
    opa_q <= opa;
    if (lo === 1'b1 && lo_q === 1'b0) n_line++;
    if (opa === 1'b1 && opa_q === 1'b0) n_op++;
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [2*STAGES-1:0] e, input logic [2*STAGES-1:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  task automatic chk_num(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_num

  // Row vector with one selected row (or none when sel is negative) under the given phase.
  function automatic logic [2*STAGES-1:0] exp_rows(input int sel, input logic ph);
    logic [2*STAGES-1:0] v;
    for (int k = 0; k < STAGES; k++) begin
      v[2*k+:2] = (k == sel) ? (ph ? LVL_SELECTED_B : LVL_SELECTED_A)
                             : (ph ? LVL_UNSELECTED_B : LVL_UNSELECTED_A);
    end
    return v;
  endfunction : exp_rows

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Straps change just after an edge, then get time to pass the synchronisers.
  task automatic straps(input logic m, input logic e, input logic d, input logic s);
    tick(1);
    ms = m;
    edge_sel = e;
    dir = d;
    stby = s;
    tick(6);
  endtask : straps

  // A start bit and 64 followers; the selected row is checked after every pulse, phase alternating.
  task automatic scan_run(input logic d);
    for (int i = 1; i <= STAGES + 1; i++) begin
      u_ctrl.send_bit(i == 1, i[0]);
      tick(10);
      chk_vec("rows", exp_rows(i > STAGES ? -1 : (d ? i - 1 : STAGES - i), i[0]), rows);
      if (i == STAGES) chk_bit("exit terminal", 1'b1, d ? rto : lfo);
    end
  endtask : scan_run

  task automatic s_reset();
    chk_bit("line oe_n", 1'b1, loe);
    chk_bit("left oe_n", 1'b1, lfoe);
    chk_vec("rows", exp_rows(-1, 1'b0), rows);
    chk_bit("overrun", 1'b0, ovr);
  endtask : s_reset

  // Slave, rising edges, scan from the left: row 1 first, left pin an input.
  task automatic s_scan_right();
    straps(1'b0, 1'b1, 1'b1, 1'b1);
    chk_bit("left oe_n", 1'b1, lfoe);
    chk_bit("right oe_n", 1'b0, rtoe);
    chk_bit("phase oe_n", 1'b1, poe);
    chk_bit("frame", 1'b0, frame_o);
    scan_run(1'b1);
  endtask : s_scan_right

  // Slave, falling edges, scan from the right: row 64 first, roles of the pins swapped.
  task automatic s_scan_left();
    straps(1'b0, 1'b0, 1'b0, 1'b1);
    chk_bit("left oe_n", 1'b0, lfoe);
    chk_bit("right oe_n", 1'b1, rtoe);
    scan_run(1'b0);
  endtask : s_scan_left

  // Standby low stalls draining; the fifth bit meets a full buffer and is dropped.
  task automatic s_overrun();
    straps(1'b0, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) u_ctrl.send_bit(i == 0, 1'b0);
    tick(10);
    chk_bit("overrun", 1'b0, ovr);
    chk_vec("rows", exp_rows(-1, 1'b0), rows);
    u_ctrl.send_bit(1'b0, 1'b0);
    tick(10);
    chk_bit("overrun", 1'b1, ovr);
    straps(1'b0, 1'b1, 1'b1, 1'b1);
    tick(10);
    chk_vec("rows", exp_rows(3, 1'b0), rows);
    // A mid-run reset is the only way to clear the sticky flag.
    rst_n = 1'b0;
    tick(3);
    chk_bit("overrun", 1'b0, ovr);
    chk_vec("rows", exp_rows(-1, 1'b0), rows);
    rst_n = 1'b1;
    tick(3);
  endtask : s_overrun

  task automatic next_frame();
    tick(1);
    while (frame_o !== 1'b0) tick(1);
    while (frame_o !== 1'b1) tick(1);
  endtask : next_frame

  // Master: pins driven out, one shift clock per row, phase toggle per frame, every duty ratio.
  task automatic s_master();
    logic ph0;
    straps(1'b1, 1'b1, 1'b1, 1'b1);
    chk_bit("line oe_n", 1'b0, loe);
    chk_bit("phase oe_n", 1'b0, poe);
    chk_bit("data oe_n", 1'b0, lfoe | rtoe);
    for (int c = 0; c < 4; c++) begin
      {dhi, dlo} = c[1:0];
      next_frame();
      tick(3);
      ph0 = po;
      chk_bit("start bit", 1'b1, lfo);
      chk_bit("op clocks", 1'b1, opa ^ opb);
      n_line = 0;
      n_op = 0;
      next_frame();
      tick(3);
      chk_num("rows per frame", DUTY_TAB[c], n_line);
      chk_num("op clock rises", DUTY_TAB[c] * ROW_TICKS_FAST / 2, n_op);
      chk_bit("phase toggled", ~ph0, po);
    end
    // Frequency select low doubles the row length; checked at the shortest duty ratio.
    freq = 1'b0;
    {dhi, dlo} = 2'h0;
    next_frame();
    tick(3);
    n_line = 0;
    n_op = 0;
    next_frame();
    tick(3);
    chk_num("slow rows per frame", DUTY_48, n_line);
    chk_num("slow op clock rises", DUTY_48 * ROW_TICKS_SLOW / 2, n_op);
  endtask : s_master

  initial begin
    ms = 1'b0;
    edge_sel = 1'b1;
    dir = 1'b1;
    dlo = 1'b1;
    dhi = 1'b1;
    freq = 1'b1;
    stby = 1'b1;
    repeat (19) @(posedge clk);
    #1;
    s_reset();
    tick(1);
    rst_n = 1'b1;
    tick(3);
    s_scan_right();
    s_scan_left();
    s_overrun();
    s_master();
    close_out();
  end
endmodule : testbench
